// File: hw/open_detect_params.svh
// Register offsets, field positions, reset values and bus codes of the open-detect bank
`ifndef OPEN_DETECT_PARAMS_SVH
`define OPEN_DETECT_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_DETECT_ENABLE 8'h23
`define IDX_OPEN_FLAGS 8'h24
`define IDX_DIAG_SEL_CH1_CH2 8'h28
`define IDX_DIAG_SEL_CH3_CH4 8'h29
`define IDX_DIAG_SEL_CH5_CH6 8'h2A
`define IDX_DETECT_QUEUE 8'h2C
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_ENABLE 8'h31
`define IDX_IRQ_CLEAR 8'h32

// Byte offset bits below the word index
`define WORD_OFFSET_BITS 2
`define WORD_OFFSET_ZERO 2'h0

// Diagnostic select field layout
`define SEL_WIDTH 3
`define SEL_LOW_LSB 0
`define SEL_HIGH_LSB 3
`define SEL_RESERVED_VALUE 2'h0

// Reset values
`define RST_OPEN_FLAGS 8'h00
`define RST_DIAG_SEL 8'h00
`define RST_DETECT_ENABLE 8'h00
`define RST_DETECT_QUEUE 8'h00
`define RST_IRQ_STATUS 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_PIN_MAP 6'h3F
`define RST_READDATA 32'h00000000

// Queue values above one mean automatic detection
`define QUEUE_AUTO_MIN 8'h02

// Avalon response codes
`define RESP_OKAY 2'h0
`define RESP_DECODE_ERROR 2'h3

`endif

// File: hw/open_detect_pkg.sv
// Types shared by the open-detect and diagnostic select bank
package open_detect_pkg;

   typedef enum logic [2:0] {
      SRC_INPUT_PIN = 3'b000,
      SRC_TEMPERATURE = 3'b001,
      SRC_REFERENCE = 3'b010,
      SRC_ANALOG_REGULATOR = 3'b011,
      SRC_DIGITAL_REGULATOR = 3'b100,
      SRC_IO_SUPPLY = 3'b101,
      SRC_ANALOG_GROUND = 3'b110,
      SRC_ANALOG_SUPPLY = 3'b111
   } source_sel_type;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_type;

endpackage : open_detect_pkg

// File: hw/diag_select_pair.sv
// One diagnostic select register holding two channel source selectors
`timescale 1ns/100ps
`include "open_detect_params.svh"

module diag_select_pair
   import open_detect_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Write side
   input wire logic write_strobe,
   input wire logic [7:0] write_data,
   // Fields
   output source_sel_type low_sel,
   output source_sel_type high_sel,
   output logic [7:0] read_value
);

   localparam logic [7:0] RESET_VALUE = `RST_DIAG_SEL;

   wire logic [2:0] next_low_bits = write_data[`SEL_LOW_LSB +: `SEL_WIDTH];
   wire logic [2:0] next_high_bits = write_data[`SEL_HIGH_LSB +: `SEL_WIDTH];

   // Reserved upper bits are never stored, so they cannot read back
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         low_sel <= source_sel_type'(RESET_VALUE[`SEL_LOW_LSB +: `SEL_WIDTH]);
         high_sel <= source_sel_type'(RESET_VALUE[`SEL_HIGH_LSB +: `SEL_WIDTH]);
      end else if (write_strobe) begin
         low_sel <= source_sel_type'(next_low_bits);
         high_sel <= source_sel_type'(next_high_bits);
      end
   end

   assign read_value = {`SEL_RESERVED_VALUE, high_sel, low_sel};

endmodule : diag_select_pair

// File: hw/open_detect_regs.sv
// Open-circuit flags, diagnostic source selects and interrupt logic on Avalon-MM
//
// What this block does
// - One open-circuit flag per channel, channel n at bit n-1 of an 8-bit register.
// - Flags reset to zero, read back, clear only on writing one; zero leaves them.
// - First select register: channel 2 in bits 5:3, channel 1 in 2:0, 7:6 reserved.
// - Second select register: channel 4 in bits 5:3, channel 3 in 2:0.
// - Third select register: channel 6 in bits 5:3, channel 5 in 2:0.
// - Selector zero converts the channel's own external input pin.
// - Non-zero selector codes route one of seven internal nodes to the channel.
// - All select registers reset to zero, so every channel uses its pin.
// - A flag sets only with detection enabled for that channel and automatic mode.
`timescale 1ns/100ps
`include "open_detect_params.svh"

module open_detect_regs
   import open_detect_pkg::*;
#(
   parameter int ADDR_WIDTH = 8,
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [ADDR_WIDTH-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic [1:0] response,
   output logic waitrequest,
   // Open-circuit detector
   input wire logic [CHANNELS-1:0] open_detect_event,
   output logic [CHANNELS-1:0] detect_enable,
   output logic detect_auto_mode,
   // Open-circuit flags
   output logic input1_open_flag,
   output logic input2_open_flag,
   output logic input3_open_flag,
   output logic input4_open_flag,
   output logic input5_open_flag,
   output logic input6_open_flag,
   output logic input7_open_flag,
   output logic input8_open_flag,
   // Channel source selectors
   output source_sel_type input1_source_sel,
   output source_sel_type input2_source_sel,
   output source_sel_type input3_source_sel,
   output source_sel_type input4_source_sel,
   output source_sel_type input5_source_sel,
   output source_sel_type input6_source_sel,
   // Pin routing per channel, channel 1 at bit 0
   output logic [5:0] channel_uses_pin,
   // Interrupt
   output logic irq
);

   localparam logic [CHANNELS-1:0] RESET_FLAGS = CHANNELS'(`RST_OPEN_FLAGS);
   localparam logic [CHANNELS-1:0] RESET_ENABLE = CHANNELS'(`RST_DETECT_ENABLE);
   localparam logic [CHANNELS-1:0] RESET_IRQ_STATUS = CHANNELS'(`RST_IRQ_STATUS);
   localparam logic [CHANNELS-1:0] RESET_IRQ_ENABLE = CHANNELS'(`RST_IRQ_ENABLE);
   localparam logic [7:0] RESET_QUEUE = `RST_DETECT_QUEUE;
   localparam logic [5:0] RESET_PIN_MAP = `RST_PIN_MAP;
   localparam logic [31:0] RESET_READDATA = `RST_READDATA;
   localparam logic [1:0] RESET_RESPONSE = `RESP_OKAY;
   localparam int INDEX_WIDTH = ADDR_WIDTH - `WORD_OFFSET_BITS;

   bus_state_type state;
   bus_state_type next_state;
   logic [CHANNELS-1:0] open_flags;
   logic [CHANNELS-1:0] next_open_flags;
   logic [CHANNELS-1:0] irq_status;
   logic [CHANNELS-1:0] next_irq_status;
   logic [CHANNELS-1:0] irq_enable;
   logic [7:0] detect_queue;
   logic [31:0] next_readdata;
   logic [1:0] next_response;

   // Address decode
   // Misaligned addresses hit nothing and answer with an error
   wire logic [INDEX_WIDTH-1:0] word_index = address[ADDR_WIDTH-1:`WORD_OFFSET_BITS];
   wire logic aligned = (address[`WORD_OFFSET_BITS-1:0] == `WORD_OFFSET_ZERO);
   wire logic hit_enable = aligned && (word_index == INDEX_WIDTH'(`IDX_DETECT_ENABLE));
   wire logic hit_flags = aligned && (word_index == INDEX_WIDTH'(`IDX_OPEN_FLAGS));
   wire logic hit_sel_12 = aligned && (word_index == INDEX_WIDTH'(`IDX_DIAG_SEL_CH1_CH2));
   wire logic hit_sel_34 = aligned && (word_index == INDEX_WIDTH'(`IDX_DIAG_SEL_CH3_CH4));
   wire logic hit_sel_56 = aligned && (word_index == INDEX_WIDTH'(`IDX_DIAG_SEL_CH5_CH6));
   wire logic hit_queue = aligned && (word_index == INDEX_WIDTH'(`IDX_DETECT_QUEUE));
   wire logic hit_irq_status = aligned && (word_index == INDEX_WIDTH'(`IDX_IRQ_STATUS));
   wire logic hit_irq_enable = aligned && (word_index == INDEX_WIDTH'(`IDX_IRQ_ENABLE));
   wire logic hit_irq_clear = aligned && (word_index == INDEX_WIDTH'(`IDX_IRQ_CLEAR));
   wire logic hit_any = hit_enable | hit_flags | hit_sel_12 | hit_sel_34 | hit_sel_56
      | hit_queue | hit_irq_status | hit_irq_enable | hit_irq_clear;

   // A request is taken only while idle, so a held request is not taken twice
   wire logic request = read || write;
   wire logic take = (state == BUS_IDLE) && request;
   wire logic read_hit = read && hit_any;

   // Writes commit only at the edge that ends the answer cycle
   // Only lane 0 carries a register; a write without it changes nothing
   wire logic lane0_write = write && byteenable[0];
   wire logic commit = (state == BUS_ANSWER) && lane0_write;
   wire logic [7:0] write_byte = writedata[7:0];
   wire logic write_enable = commit && hit_enable;
   wire logic write_flags = commit && hit_flags;
   wire logic write_sel_12 = commit && hit_sel_12;
   wire logic write_sel_34 = commit && hit_sel_34;
   wire logic write_sel_56 = commit && hit_sel_56;
   wire logic write_queue = commit && hit_queue;
   wire logic write_irq_enable = commit && hit_irq_enable;
   wire logic write_irq_clear = commit && hit_irq_clear;

   // Flag set and clear terms
   // Queue of one is manual mode, where no flag may set
   wire logic auto_mode = (detect_queue >= `QUEUE_AUTO_MIN);
   wire logic [CHANNELS-1:0] auto_gate = {CHANNELS{auto_mode}};
   wire logic [CHANNELS-1:0] armed = detect_enable & auto_gate;
   wire logic [CHANNELS-1:0] flag_set =
      open_detect_event & armed;
   wire logic [CHANNELS-1:0] flag_clear =
      write_flags ? write_byte[CHANNELS-1:0] : '0;
   wire logic [CHANNELS-1:0] irq_clear =
      write_irq_clear ? write_byte[CHANNELS-1:0] : '0;

   // Set beats a clear landing in the same cycle
   assign next_open_flags = (open_flags & ~flag_clear) | flag_set;
   assign next_irq_status = (irq_status & ~irq_clear) | flag_set;

   // Enable as it stands after this edge, so a new enable raises irq at once
   wire logic [CHANNELS-1:0] next_irq_enable =
      write_irq_enable ? write_byte[CHANNELS-1:0] : irq_enable;
   wire logic next_irq = |(next_irq_status & next_irq_enable);

   // Detector control loads whole bytes on a committed write
   wire logic [CHANNELS-1:0] next_detect_enable =
      write_enable ? write_byte[CHANNELS-1:0] : detect_enable;
   wire logic [7:0] next_detect_queue = write_queue ? write_byte : detect_queue;

   // Select register contents
   // Selector ports change at the commit edge; routing follows a cycle later
   wire logic [7:0] sel_12_value;
   wire logic [7:0] sel_34_value;
   wire logic [7:0] sel_56_value;

   diag_select_pair u_sel_ch1_ch2 (
      .clock(clock),
      .reset_n(reset_n),
      .write_strobe(write_sel_12),
      .write_data(write_byte),
      .low_sel(input1_source_sel),
      .high_sel(input2_source_sel),
      .read_value(sel_12_value)
   );

   diag_select_pair u_sel_ch3_ch4 (
      .clock(clock),
      .reset_n(reset_n),
      .write_strobe(write_sel_34),
      .write_data(write_byte),
      .low_sel(input3_source_sel),
      .high_sel(input4_source_sel),
      .read_value(sel_34_value)
   );

   diag_select_pair u_sel_ch5_ch6 (
      .clock(clock),
      .reset_n(reset_n),
      .write_strobe(write_sel_56),
      .write_data(write_byte),
      .low_sel(input5_source_sel),
      .high_sel(input6_source_sel),
      .read_value(sel_56_value)
   );

   // Zero selects the external pin, anything else an internal node
   wire logic [5:0] next_channel_uses_pin = {
      input6_source_sel == SRC_INPUT_PIN,
      input5_source_sel == SRC_INPUT_PIN,
      input4_source_sel == SRC_INPUT_PIN,
      input3_source_sel == SRC_INPUT_PIN,
      input2_source_sel == SRC_INPUT_PIN,
      input1_source_sel == SRC_INPUT_PIN
   };

   // Read multiplexer; unused lanes read zero
   wire logic [7:0] read_enable = 8'(detect_enable);
   wire logic [7:0] read_flags = 8'(open_flags);
   wire logic [7:0] read_irq_status = 8'(irq_status);
   wire logic [7:0] read_irq_enable = 8'(irq_enable);
   wire logic [7:0] read_byte =
      hit_enable ? read_enable :
      hit_flags ? read_flags :
      hit_sel_12 ? sel_12_value :
      hit_sel_34 ? sel_34_value :
      hit_sel_56 ? sel_56_value :
      hit_queue ? detect_queue :
      hit_irq_status ? read_irq_status :
      hit_irq_enable ? read_irq_enable :
      8'h00;

   // Clear register is write-only and reads zero
   assign next_readdata = read_hit ? {24'h000000, read_byte} : 32'h00000000;
   assign next_response = hit_any ? `RESP_OKAY : `RESP_DECODE_ERROR;

   // One wait cycle per access; a new request is seen the cycle after release
   always_comb begin
      next_state = state;
      case (state)
         BUS_IDLE: begin
            if (request) begin
               next_state = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            next_state = BUS_IDLE;
         end
         default: begin
            next_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= BUS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Low for exactly the answer cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= (next_state != BUS_ANSWER);
      end
   end

   // Read data captured while the request waits, held for the answer cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         readdata <= RESET_READDATA;
      end else if (take) begin
         readdata <= next_readdata;
      end
   end

   // Response for the request being taken
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         response <= RESET_RESPONSE;
      end else if (take) begin
         response <= next_response;
      end
   end

   // Open-circuit flags
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         open_flags <= RESET_FLAGS;
      end else begin
         open_flags <= next_open_flags;
      end
   end

   // Channel n is bit n-1
   assign input1_open_flag = open_flags[0];
   assign input2_open_flag = open_flags[1];
   assign input3_open_flag = open_flags[2];
   assign input4_open_flag = open_flags[3];
   assign input5_open_flag = open_flags[4];
   assign input6_open_flag = open_flags[5];
   assign input7_open_flag = open_flags[6];
   assign input8_open_flag = open_flags[7];

   // Detector control
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         detect_enable <= RESET_ENABLE;
      end else begin
         detect_enable <= next_detect_enable;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         detect_queue <= RESET_QUEUE;
      end else begin
         detect_queue <= next_detect_queue;
      end
   end

   // Registered copy so the detector sees a clean level
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         detect_auto_mode <= 1'b0;
      end else begin
         detect_auto_mode <= auto_mode;
      end
   end

   // Routing status lags the select registers by one cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         channel_uses_pin <= RESET_PIN_MAP;
      end else begin
         channel_uses_pin <= next_channel_uses_pin;
      end
   end

   // Interrupt status, enable and output
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq_status <= RESET_IRQ_STATUS;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq_enable <= RESET_IRQ_ENABLE;
      end else begin
         irq_enable <= next_irq_enable;
      end
   end

   // Computed from next status so irq tracks the status register exactly
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

endmodule : open_detect_regs

// File: testbench/open_detect_regs_sva.sv
// Assertion checker for the open-detect register bank
`timescale 1ns/100ps
`include "open_detect_params.svh"

module open_detect_regs_sva
   import open_detect_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int ADDR_WIDTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Bus
   input wire logic [ADDR_WIDTH-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic [1:0] response,
   input wire logic waitrequest,
   // Detector, flags, interrupt
   input wire logic [CHANNELS-1:0] open_detect_event,
   input wire logic [CHANNELS-1:0] detect_enable,
   input wire logic detect_auto_mode,
   input wire logic input1_open_flag,
   input wire logic input8_open_flag,
   input wire logic irq,
   // Selectors
   input wire source_sel_type input1_source_sel,
   input wire source_sel_type input6_source_sel,
   input wire logic [5:0] channel_uses_pin
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   property p_wait_one;
      (read || write) && waitrequest && $past(waitrequest) |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer not one cycle");
   property p_pin_low;
      (input1_source_sel == SRC_INPUT_PIN) |=> channel_uses_pin[0];
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("channel 1 not on pin");
   property p_pin_high;
      (input6_source_sel != SRC_INPUT_PIN) |=> !channel_uses_pin[5];
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("channel 6 on pin");
   property p_flag_set;
      $rose(input1_open_flag) |-> $past(open_detect_event[0] && detect_enable[0])
         && ($past(detect_auto_mode) || detect_auto_mode);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag 1 set unqualified");
   property p_flag_bit;
      $rose(input8_open_flag) |-> $past(open_detect_event[7] && detect_enable[7]);
   endproperty
   a_flag_bit: assert property (p_flag_bit) else $error("flag 8 bit wrong");
   property p_flag_hold;
      input1_open_flag && !write |=> input1_open_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without write");
   property p_sel_stable;
      !write |=> $stable(input1_source_sel) && $stable(input6_source_sel);
   endproperty
   a_sel_stable: assert property (p_sel_stable) else $error("select moved");
   property p_upper_zero;
      readdata[31:8] == 24'h0 && (response == 2'h3 -> readdata == 32'h0);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("read data not zero");
   property p_reserved_zero;
      read && !waitrequest
         && address[ADDR_WIDTH-1:2] inside {[`IDX_DIAG_SEL_CH1_CH2:`IDX_DIAG_SEL_CH5_CH6]}
         |-> readdata[7:6] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   cover property ($rose(input1_open_flag));
   cover property (response == 2'h3);
   cover property ($rose(irq));
endmodule : open_detect_regs_sva

bind open_detect_regs open_detect_regs_sva #(.CHANNELS(CHANNELS), .ADDR_WIDTH(ADDR_WIDTH)) i_sva (
   .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
   .readdata(readdata),
   .response(response), .waitrequest(waitrequest), .open_detect_event(open_detect_event),
   .detect_enable(detect_enable), .detect_auto_mode(detect_auto_mode), .irq(irq),
   .input1_open_flag(input1_open_flag), .input8_open_flag(input8_open_flag),
   .input1_source_sel(input1_source_sel), .input6_source_sel(input6_source_sel),
   .channel_uses_pin(channel_uses_pin));

// File: testbench/open_detect_regs_test.sv
// Self-checking testbench for the open-detect register bank
`timescale 1ns/100ps
`include "open_detect_params.svh"

module open_detect_regs_test
   import open_detect_pkg::*;
;
   logic clock;
   logic reset_n;
   logic [7:0] address;
   logic read;
   logic write;
   logic [3:0] byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic [1:0] response;
   logic waitrequest;
   logic [7:0] open_detect_event;
   logic [7:0] detect_enable;
   logic detect_auto_mode;
   wire logic [7:0] flags;
   wire source_sel_type sel [6];
   logic [5:0] channel_uses_pin;
   logic irq;
   int err_total;
   int cmp_count;
   logic [31:0] rdata;
   logic [1:0] rresp;

   open_detect_regs i_dut (
      .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .response(response), .waitrequest(waitrequest), .open_detect_event(open_detect_event),
      .detect_enable(detect_enable), .detect_auto_mode(detect_auto_mode),
      .input1_open_flag(flags[0]), .input2_open_flag(flags[1]), .input3_open_flag(flags[2]),
      .input4_open_flag(flags[3]), .input5_open_flag(flags[4]), .input6_open_flag(flags[5]),
      .input7_open_flag(flags[6]), .input8_open_flag(flags[7]),
      .input1_source_sel(sel[0]), .input2_source_sel(sel[1]), .input3_source_sel(sel[2]),
      .input4_source_sel(sel[3]), .input5_source_sel(sel[4]), .input6_source_sel(sel[5]),
      .channel_uses_pin(channel_uses_pin), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Request held until waitrequest is sampled low
   task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clock);
      address <= {idx[5:0], 2'h0};
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      @(posedge clock);
      while (waitrequest !== 1'b0)
         @(posedge clock);
      rdata = readdata;
      rresp = response;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
      bus(1'b0, idx, 8'h00);
      check(name, rdata, {24'h0, exp});
      check({name, "_resp"}, {30'h0, rresp}, {30'h0, `RESP_OKAY});
   endtask : rd

   task pulse(input logic [7:0] ev);
      @(posedge clock);
      open_detect_event <= ev;
      @(posedge clock);
      open_detect_event <= 8'h00;
   endtask : pulse

   task t_reset;
      rd(`IDX_OPEN_FLAGS, 8'h00, "flags_reset");
      for (int r = 0; r < 3; r++)
         rd(`IDX_DIAG_SEL_CH1_CH2 + r[7:0], 8'h00, "sel_reset");
      check("pin_reset", {26'h0, channel_uses_pin}, 32'h3F);
      check("sel1_reset", {29'h0, sel[0]}, {29'h0, SRC_INPUT_PIN});
   endtask : t_reset

   // Every code in every field; reserved bits written as ones
   task t_select;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         for (int r = 0; r < 3; r++)
            bus(1'b1, `IDX_DIAG_SEL_CH1_CH2 + r[7:0], {2'h3, c, ~c});
         for (int r = 0; r < 3; r++)
            rd(`IDX_DIAG_SEL_CH1_CH2 + r[7:0], {2'h0, c, ~c}, "sel_reg");
         check("sel_ports", {14'h0, sel[5], sel[4], sel[3], sel[2], sel[1], sel[0]},
            {14'h0, {3{c, ~c}}});
         check("pin_map", {26'h0, channel_uses_pin},
            {26'h0, {3{c == 3'h0, ~c == 3'h0}}});
      end
   endtask : t_select

   task t_flags;
      pulse(8'hFF);
      rd(`IDX_OPEN_FLAGS, 8'h00, "flags_disabled");
      bus(1'b1, `IDX_DETECT_ENABLE, 8'hFF);
      bus(1'b1, `IDX_DETECT_QUEUE, 8'h01);
      check("detect_enable", {24'h0, detect_enable}, 32'hFF);
      pulse(8'hFF);
      check("auto_off", {31'h0, detect_auto_mode}, 32'h0);
      rd(`IDX_OPEN_FLAGS, 8'h00, "flags_manual");
      bus(1'b1, `IDX_DETECT_QUEUE, 8'h02);
      pulse(8'hA5);
      check("auto_on", {31'h0, detect_auto_mode}, 32'h1);
      rd(`IDX_OPEN_FLAGS, 8'hA5, "flags_auto");
      check("flag_ports", {24'h0, flags}, 32'hA5);
      bus(1'b1, `IDX_OPEN_FLAGS, 8'h00);
      rd(`IDX_OPEN_FLAGS, 8'hA5, "flags_w0");
      bus(1'b1, `IDX_OPEN_FLAGS, 8'h05);
      rd(`IDX_OPEN_FLAGS, 8'hA0, "flags_w1c");
      rd(`IDX_IRQ_STATUS, 8'hA5, "irq_status");
      bus(1'b1, `IDX_IRQ_ENABLE, 8'h02);
      repeat (2) @(posedge clock);
      check("irq_masked", {31'h0, irq}, 32'h0);
      bus(1'b1, `IDX_IRQ_ENABLE, 8'h01);
      repeat (2) @(posedge clock);
      check("irq_on", {31'h0, irq}, 32'h1);
      bus(1'b1, `IDX_IRQ_CLEAR, 8'hFF);
      repeat (2) @(posedge clock);
      check("irq_off", {31'h0, irq}, 32'h0);
      rd(`IDX_IRQ_STATUS, 8'h00, "irq_cleared");
      // Event lands on the same edge as the clear of its flag: the set wins
      fork
         bus(1'b1, `IDX_OPEN_FLAGS, 8'h01);
         begin
            repeat (2) @(posedge clock);
            open_detect_event <= 8'h01;
            @(posedge clock);
            open_detect_event <= 8'h00;
         end
      join
      rd(`IDX_OPEN_FLAGS, 8'hA1, "flags_set_wins");
      check("irq_again", {31'h0, irq}, 32'h1);
   endtask : t_flags

   task t_unmapped;
      bus(1'b1, 8'h3F, 8'hFF);
      check("unmapped_wr", {30'h0, rresp}, {30'h0, `RESP_DECODE_ERROR});
      bus(1'b0, 8'h3F, 8'h00);
      check("unmapped_rd", rdata, 32'h0);
      check("unmapped_rd_resp", {30'h0, rresp}, {30'h0, `RESP_DECODE_ERROR});
      byteenable <= 4'hE;
      bus(1'b1, `IDX_DIAG_SEL_CH1_CH2, 8'h07);
      byteenable <= 4'hF;
      rd(`IDX_DIAG_SEL_CH1_CH2, 8'h38, "sel_kept");
   endtask : t_unmapped

   // Watchdog well beyond the few hundred cycles of the sequence
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      end_sim;
   end

   initial begin
      reset_n = 1'b0;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'hF;
      writedata = 32'h0;
      open_detect_event = 8'h00;
      err_total = 0;
      cmp_count = 0;
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      t_reset;
      t_select;
      t_flags;
      t_unmapped;
      end_sim;
   end
endmodule : open_detect_regs_test
